/* inc/mode_strap_pkg.sv */
// Types shared by the strap capture and path power control block.
package mode_strap_pkg;

    typedef enum logic [1:0] {
        full_duplex_mode,
        half_duplex_interleaved_mode,
        half_duplex_parallel_mode
    } iface_mode_t;

    typedef enum logic {
        cfg_capture,
        cfg_hold
    } cfg_phase_t;

    typedef struct packed {
        logic       serial_enable;
        logic       duplex_full;
        logic       interp_high;
        logic       interp_low;
        logic       bus_interleaved;
        logic       economy;
        logic [2:0] spare;
    } strap_set_t;

    typedef struct packed {
        logic rx_digital_clk_on;
        logic tx_digital_clk_on;
        logic rx_analog_on;
        logic tx_analog_on;
        logic pll_on;
    } path_power_t;

endpackage

/* inc/mode_strap_regs.svh */
// Constants for the strap capture and path power control block.
`ifndef MODE_STRAP_REGS_SVH
`define MODE_STRAP_REGS_SVH

// Upsampling and PLL factor codes carried on two strap or serial bits.
`define UPSAMPLE_CODE_1X   2'h0
`define UPSAMPLE_CODE_2X   2'h1
`define UPSAMPLE_CODE_4X   2'h2

// Positions of the pins inside the synchronised pin vector.
`define PIN_SERIAL_ENABLE  8
`define PIN_DUPLEX         7
`define PIN_INTERP_HIGH    6
`define PIN_INTERP_LOW     5
`define PIN_BUS_WIDTH      4
`define PIN_ECONOMY        3
`define PIN_RX_SLEEP       2
`define PIN_TX_SLEEP       1
`define PIN_DIRECTION      0
`define PIN_COUNT          9

// Reset values of the held configuration and of the outputs.
`define RESET_STRAPS       9'h000
`define RESET_UPSAMPLE     2'h0
`define RESET_POWER        5'h00

`endif

/* rtl/mode_strap_power_control.sv */
// Strap capture at reset release and live receive and transmit power control.
// Functional notes
// - Capture every strap at reset release.
// - Strap select low keeps serial port off.
// - Strap select high enables serial port settings.
// - Duplex strap low selects half duplex.
// - Width strap picks parallel or interleaved half.
// - Interp straps set upsampling and PLL factor.
// - Economy strap selects reduced converter power.
// - Receive sleep pin stops receive clocks continuously.
// - Sleep pins cut fast analog circuits.
// - Transmit sleep pin stops converter clocks.
// - PLL stays powered unless serially shut off.
// - Selector low stops transmit, bus drives.
// - Selector high stops receive, bus inputs.
// - Selector acts only in half duplex.
// - Interleaved half mode floats unused bus half.
`timescale 1ns/1ps
`include "mode_strap_regs.svh"
module mode_strap_power_control
    import mode_strap_pkg::*;
(
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Configuration straps, sampled when reset is released.
    input  wire logic        serial_enable_strap_pin,
    input  wire logic        serial_out_duplex_strap,
    input  wire logic        serial_io_interp_high_strap,
    input  wire logic        serial_clock_interp_low_strap,
    input  wire logic        bus_width_strap_pin,
    input  wire logic        converter_economy_strap,
    // Live control pins.
    input  wire logic        receive_path_sleep_pin,
    input  wire logic        transmit_path_sleep_pin,
    input  wire logic        direction_select_pin,
    // Settings from the serial register file, same clock.
    input  wire logic        serial_duplex_full,
    input  wire logic        serial_bus_interleaved,
    input  wire logic [1:0]  serial_upsample_code,
    input  wire logic        serial_pll_off,
    // Configuration outputs.
    output logic             config_valid,
    output logic             serial_port_on,
    output logic             serial_pins_are_straps,
    output iface_mode_t      iface_mode,
    output logic [1:0]       upsample_code,
    output logic [1:0]       pll_factor_code,
    output logic             converter_economy,
    // Power and bus direction outputs.
    output path_power_t      power_state,
    output logic             upper_bus_oe,
    output logic             lower_bus_oe
);

    function automatic iface_mode_t mode_decode(input logic full, input logic interleaved);
        if (full) begin
            return full_duplex_mode;
        end else if (interleaved) begin
            return half_duplex_interleaved_mode;
        end
        return half_duplex_parallel_mode;
    endfunction

    logic [`PIN_COUNT-1:0] pins_s;
    cfg_phase_t            phase_reg;
    strap_set_t            strap_reg;
    logic                  valid_reg;
    logic                  serial_on_reg;
    logic                  straps_on_pins_reg;
    iface_mode_t           mode_reg;
    logic [1:0]            upsample_reg;
    logic [1:0]            pll_factor_reg;
    logic                  economy_reg;
    path_power_t           power_reg;
    logic                  upper_oe_reg;
    logic                  lower_oe_reg;

    pin_sync #(
        .W(`PIN_COUNT)
    ) u_pin_sync (
        .ref_clk    (ref_clk),
        .pins_async ({serial_enable_strap_pin, serial_out_duplex_strap,
                      serial_io_interp_high_strap, serial_clock_interp_low_strap,
                      bus_width_strap_pin, converter_economy_strap,
                      receive_path_sleep_pin, transmit_path_sleep_pin,
                      direction_select_pin}),
        .pins_sync  (pins_s)
    );

    // Live pins after synchronisation.
    wire rx_sleep = pins_s[`PIN_RX_SLEEP];
    wire tx_sleep = pins_s[`PIN_TX_SLEEP];
    wire dir_tx   = pins_s[`PIN_DIRECTION];

    // Strap sample taken at the first edge after reset release.
    strap_set_t strap_sample;
    assign strap_sample = '{
        serial_enable:   pins_s[`PIN_SERIAL_ENABLE],
        duplex_full:     pins_s[`PIN_DUPLEX],
        interp_high:     pins_s[`PIN_INTERP_HIGH],
        interp_low:      pins_s[`PIN_INTERP_LOW],
        bus_interleaved: pins_s[`PIN_BUS_WIDTH],
        economy:         pins_s[`PIN_ECONOMY],
        spare:           3'h0
    };

    // Effective configuration: serial settings replace the straps when enabled.
    wire         spi_on      = strap_reg.serial_enable;
    wire iface_mode_t strap_mode = mode_decode(strap_reg.duplex_full,
                                               strap_reg.bus_interleaved);
    wire iface_mode_t spi_mode   = mode_decode(serial_duplex_full, serial_bus_interleaved);
    wire iface_mode_t mode_next  = iface_mode_t'(spi_on ? spi_mode : strap_mode);
    wire [1:0]   code_next   = spi_on ? serial_upsample_code
                                      : {strap_reg.interp_high, strap_reg.interp_low};
    wire         half_duplex = (mode_next != full_duplex_mode);

    // The selector only steers the paths in half duplex; full duplex runs both.
    wire rx_selected = !half_duplex || !dir_tx;
    wire tx_selected = !half_duplex || dir_tx;
    wire rx_live     = valid_reg && !rx_sleep && rx_selected;
    wire tx_live     = valid_reg && !tx_sleep && tx_selected;

    path_power_t power_next;
    assign power_next = '{
        rx_digital_clk_on: rx_live,
        tx_digital_clk_on: tx_live,
        rx_analog_on:      valid_reg && !rx_sleep,
        tx_analog_on:      valid_reg && !tx_sleep,
        pll_on:            valid_reg && !(spi_on && serial_pll_off)
    };

    // Receive data leaves on the lower half; the upper half joins only in the
    // parallel mode, so in the interleaved mode the upper half may be tied.
    wire lower_oe_next = rx_live;
    wire upper_oe_next = rx_live && (mode_next == half_duplex_parallel_mode);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= cfg_capture;
            strap_reg <= `RESET_STRAPS;
            valid_reg <= 1'b0;
        end else begin
            case (phase_reg)
                cfg_capture: begin
                    strap_reg <= strap_sample;
                    valid_reg <= 1'b1;
                    phase_reg <= cfg_hold;
                end
                cfg_hold: begin
                    phase_reg <= cfg_hold;
                end
                default: begin
                    phase_reg <= cfg_capture;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            serial_on_reg      <= 1'b0;
            straps_on_pins_reg <= 1'b0;
            mode_reg           <= full_duplex_mode;
            upsample_reg       <= `RESET_UPSAMPLE;
            pll_factor_reg     <= `RESET_UPSAMPLE;
            economy_reg        <= 1'b0;
            power_reg          <= `RESET_POWER;
            upper_oe_reg       <= 1'b0;
            lower_oe_reg       <= 1'b0;
        end else begin
            serial_on_reg      <= valid_reg && spi_on;
            straps_on_pins_reg <= valid_reg && !spi_on;
            mode_reg           <= mode_next;
            upsample_reg       <= code_next;
            pll_factor_reg     <= code_next;
            economy_reg        <= strap_reg.economy;
            power_reg          <= power_next;
            upper_oe_reg       <= upper_oe_next;
            lower_oe_reg       <= lower_oe_next;
        end
    end

    assign config_valid           = valid_reg;
    assign serial_port_on         = serial_on_reg;
    assign serial_pins_are_straps = straps_on_pins_reg;
    assign iface_mode             = mode_reg;
    assign upsample_code          = upsample_reg;
    assign pll_factor_code        = pll_factor_reg;
    assign converter_economy      = economy_reg;
    assign power_state            = power_reg;
    assign upper_bus_oe           = upper_oe_reg;
    assign lower_bus_oe           = lower_oe_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    chk_strap_hold_stable: assert property (
        valid_reg && $past(valid_reg) |-> $stable(strap_reg) && phase_reg == cfg_hold
    ) else $error("held straps changed after capture");

    chk_capture_once: assert property (
        phase_reg == cfg_capture |=> valid_reg && strap_reg == $past(strap_sample)
    ) else $error("straps not captured at reset release");

    chk_serial_port_off: assert property (
        valid_reg && !spi_on |=> !serial_port_on && serial_pins_are_straps
    ) else $error("serial port active with select strap low");

    chk_serial_replaces_straps: assert property (
        valid_reg && spi_on |=> serial_port_on
            && upsample_code == $past(serial_upsample_code)
            && iface_mode == $past(spi_mode)
    ) else $error("serial settings not applied");

    chk_duplex_strap_mode: assert property (
        valid_reg && !spi_on && strap_reg.duplex_full |=> iface_mode == full_duplex_mode
    ) else $error("duplex strap high did not give full duplex");

    chk_width_strap_mode: assert property (
        valid_reg && !spi_on && !strap_reg.duplex_full |=>
            iface_mode == ($past(strap_reg.bus_interleaved) ? half_duplex_interleaved_mode
                                                            : half_duplex_parallel_mode)
    ) else $error("width strap decoded wrongly");

    chk_upsample_pll_match: assert property (
        valid_reg && !spi_on |=> pll_factor_code == upsample_code
            && upsample_code == {$past(strap_reg.interp_high), $past(strap_reg.interp_low)}
    ) else $error("upsampling or PLL factor mismatch");

    chk_economy_follow: assert property (
        valid_reg |=> converter_economy == $past(strap_reg.economy)
    ) else $error("economy output differs from strap");

    chk_rx_sleep_power: assert property (
        rx_sleep |=> !power_state.rx_digital_clk_on && !power_state.rx_analog_on
            && !lower_bus_oe && !upper_bus_oe
    ) else $error("receive path running during sleep");

    chk_tx_sleep_pll: assert property (
        valid_reg && tx_sleep && !(spi_on && serial_pll_off) |=>
            !power_state.tx_digital_clk_on && !power_state.tx_analog_on && power_state.pll_on
    ) else $error("transmit sleep handled wrongly");

    chk_dir_low_receive: assert property (
        valid_reg && half_duplex && !dir_tx && !rx_sleep && !tx_sleep |=>
            !power_state.tx_digital_clk_on && power_state.tx_analog_on
            && power_state.rx_digital_clk_on && power_state.rx_analog_on && lower_bus_oe
    ) else $error("selector low did not choose receive");

    chk_dir_high_transmit: assert property (
        valid_reg && half_duplex && dir_tx && !rx_sleep |=>
            !power_state.rx_digital_clk_on && power_state.rx_analog_on
            && !lower_bus_oe && !upper_bus_oe
    ) else $error("selector high did not choose transmit");

    chk_full_duplex_both: assert property (
        valid_reg && !half_duplex && !rx_sleep && !tx_sleep |=>
            power_state.rx_digital_clk_on && power_state.tx_digital_clk_on
    ) else $error("selector acted in full duplex");

    chk_interleaved_upper_off: assert property (
        iface_mode != half_duplex_parallel_mode |-> !upper_bus_oe
    ) else $error("upper bus half driven outside parallel mode");

endmodule

/* rtl/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 9
) (
    // Clock.
    input  wire logic         ref_clk,
    // Pins and their synchronised copies.
    input  wire logic [W-1:0] pins_async,
    output logic      [W-1:0] pins_sync
);

    // No reset here on purpose: the straps must already be settled in the
    // second stage at the first edge after reset is released.
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    always_ff @(posedge ref_clk) begin
        stage1_reg <= pins_async;
        stage2_reg <= stage1_reg;
    end

    assign pins_sync = stage2_reg;

endmodule

/* tb/strap_board_model.sv */
// Board straps and controller pins that face the strap capture block.
`timescale 1ns/1ps
module strap_board_model
    import mode_strap_pkg::*;
(
    // Clock and reset as seen on the board.
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Configuration the controller wants at the next reset release.
    input  wire strap_set_t  want,
    // Strap pins.
    output logic             serial_enable_strap_pin,
    output logic             serial_out_duplex_strap,
    output logic             serial_io_interp_high_strap,
    output logic             serial_clock_interp_low_strap,
    output logic             bus_width_strap_pin,
    output logic             converter_economy_strap
);
    logic [1:0] age_reg;
    logic       churn;
    logic [1:0] code;

    // Shared pins carry other traffic once the capture window has passed.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            age_reg <= 2'h0;
        end else if (age_reg != 2'h3) begin
            age_reg <= age_reg + 2'h1;
        end
    end
    assign churn = (age_reg == 2'h3);
    // Full duplex cannot run at 1x, so a 1x request is raised to 2x there.
    assign code = (want.duplex_full && {want.interp_high, want.interp_low} == 2'h0) ?
                  2'h1 : {want.interp_high, want.interp_low};
    assign serial_enable_strap_pin       = want.serial_enable ^ churn;
    assign serial_out_duplex_strap       = want.duplex_full ^ churn;
    assign serial_io_interp_high_strap   = code[1] ^ churn;
    assign serial_clock_interp_low_strap = code[0] ^ churn;
    assign bus_width_strap_pin           = want.bus_interleaved ^ churn;
    assign converter_economy_strap       = want.economy ^ churn;
endmodule

/* tb/tb_mode_strap_power_control.sv */
// Self-checking bench for strap capture and path power control.
`timescale 1ns/1ps
module tb_mode_strap_power_control;
    import mode_strap_pkg::*;
    logic        ref_clk, nrst, se_pin, dup_pin, ih_pin, il_pin, w_pin, eco_pin;
    logic        rx_sleep, tx_sleep, dir, s_dup, s_il, s_pll_off;
    logic [1:0]  s_code;
    strap_set_t  want;
    logic        valid, sp_on, sp_straps, economy, up_oe, lo_oe;
    iface_mode_t mode;
    logic [1:0]  up_code, pll_code;
    path_power_t power;
    logic [9:0]  cfg_got;
    logic [6:0]  pwr_got;
    int          error_cnt, n_compared, cyc;
    logic [10:0] tbl [6] = '{11'b01010000001, 11'b00101111010, 11'b00000011101,
                             11'b10000100101, 11'b10101010010, 11'b11001101010};

    assign cfg_got = {valid, sp_on, sp_straps, mode, up_code, pll_code, economy};
    assign pwr_got = {power, up_oe, lo_oe};

    strap_board_model u_strap_board_model (.ref_clk(ref_clk), .nrst(nrst), .want(want),
        .serial_enable_strap_pin(se_pin), .serial_out_duplex_strap(dup_pin),
        .serial_io_interp_high_strap(ih_pin), .serial_clock_interp_low_strap(il_pin),
        .bus_width_strap_pin(w_pin), .converter_economy_strap(eco_pin));

    mode_strap_power_control u_mode_strap_power_control (.ref_clk(ref_clk), .nrst(nrst),
        .serial_enable_strap_pin(se_pin), .serial_out_duplex_strap(dup_pin),
        .serial_io_interp_high_strap(ih_pin), .serial_clock_interp_low_strap(il_pin),
        .bus_width_strap_pin(w_pin), .converter_economy_strap(eco_pin),
        .receive_path_sleep_pin(rx_sleep), .transmit_path_sleep_pin(tx_sleep),
        .direction_select_pin(dir), .serial_duplex_full(s_dup),
        .serial_bus_interleaved(s_il), .serial_upsample_code(s_code),
        .serial_pll_off(s_pll_off), .config_valid(valid), .serial_port_on(sp_on),
        .serial_pins_are_straps(sp_straps), .iface_mode(mode), .upsample_code(up_code),
        .pll_factor_code(pll_code), .converter_economy(economy), .power_state(power),
        .upper_bus_oe(up_oe), .lower_bus_oe(lo_oe));

    task automatic summarize();
        $display("Counts: %0d compared, %0d mismatched", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic compare(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Receive clock runs unless asleep or, in half duplex, turned to transmit.
    function automatic logic [6:0] pwr_exp(input logic full, input logic par,
                                           input logic [2:0] live, input logic pll_off);
        logic rxc;
        logic txc;
        rxc = !live[2] && (full || !live[0]);
        txc = !live[1] && (full || live[0]);
        return {rxc, txc, !live[2], !live[1], !pll_off, rxc && par, rxc};
    endfunction

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // The whole run needs well under a thousand cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        logic [10:0] t;
        logic        full;
        logic        inter;
        logic [1:0]  code;
        nrst = 1'b0;
        want = strap_set_t'(9'h000);
        {rx_sleep, tx_sleep, dir, s_dup, s_il, s_pll_off, s_code} = 8'h00;
        for (int i = 0; i < 6; i++) begin
            t = tbl[i];
            @(negedge ref_clk);
            nrst = 1'b0;
            want = strap_set_t'({t[10:5], 3'h0});
            {s_dup, s_il, s_code, s_pll_off} = t[4:0];
            {rx_sleep, tx_sleep, dir} = 3'h0;
            @(negedge ref_clk);
            compare(cfg_got, 10'h000);
            repeat (10) @(negedge ref_clk);
            nrst = 1'b1;
            full = t[10] ? t[4] : t[9];
            inter = t[10] ? t[3] : t[6];
            code = t[10] ? t[2:1] : t[8:7];
            repeat (4) @(negedge ref_clk);
            for (int j = 0; j < 8; j++) begin
                {rx_sleep, tx_sleep, dir} = 3'(j);
                repeat (4) @(negedge ref_clk);
                compare({3'h0, pwr_got}, {3'h0, pwr_exp(full, !full && !inter, 3'(j),
                        t[10] && t[0])});
            end
            compare(cfg_got, {1'b1, t[10], !t[10], full ? 2'h0 : (inter ? 2'h1 : 2'h2),
                    code, code, t[5]});
            $display("test %0d done, %0d mismatches so far", i, error_cnt);
        end
        summarize();
    end
endmodule
